/* File: hw/serial_port_pkg.sv */
/*
 Constants for the FIFO asynchronous serial port: register offsets,
 field positions, reset values and state types.
 Assumes a 32-bit APB slave with byte addresses on word boundaries.
*/
`default_nettype none
package serial_port_pkg;
   localparam int FIFO_DEPTH = 16;
   // Byte addresses
   localparam logic [7:0] OFS_STOP = 8'h00;
   localparam logic [7:0] OFS_SCR = 8'h04;
   localparam logic [7:0] OFS_FCR = 8'h08;
   localparam logic [7:0] OFS_FSR = 8'h0C;
   localparam logic [7:0] OFS_SMR = 8'h10;
   localparam logic [7:0] OFS_TDR = 8'h14;
   localparam logic [7:0] OFS_RDR = 8'h18;
   localparam logic [7:0] OFS_BRR = 8'h1C;
   // module_clock_stop_ctrl
   localparam int STOP_SELF = 6;
   localparam int STOP_LO = 2;
   // serial_control
   localparam int SCR_TXI_EN = 7;
   localparam int SCR_RXI_EN = 6;
   localparam int SCR_TX_EN = 5;
   localparam int SCR_RX_EN = 4;
   localparam int SCR_FLT_EN = 3;
   localparam logic [7:0] SCR_MASK = 8'hFB;
   // fifo_control
   localparam int FCR_FLOW_LO = 8;
   localparam int FCR_RXTH_LO = 6;
   localparam int FCR_TXTH_LO = 4;
   localparam int FCR_FLOW_EN = 3;
   localparam int FCR_TX_CLR = 2;
   localparam int FCR_RX_CLR = 1;
   localparam int FCR_LOOP = 0;
   // serial_status
   localparam int FSR_FAULT = 7;
   localparam int FSR_TXLOW = 5;
   localparam int FSR_BREAK = 4;
   localparam int FSR_PEND = 0;
   localparam int FL_POS [4] = '{FSR_PEND, FSR_BREAK, FSR_TXLOW, FSR_FAULT};
   localparam int FL_PEND = 0;
   localparam int FL_BREAK = 1;
   localparam int FL_TXLOW = 2;
   localparam int FL_FAULT = 3;
   // serial_mode
   localparam int SMR_LEN7 = 6;
   localparam int SMR_PAR = 5;
   localparam int SMR_OE = 4;
   localparam int SMR_STOP = 3;
   localparam int SMR_CLK_LO = 0;
   localparam logic [7:0] SMR_MASK = 8'hFB;
   // Reset values
   localparam logic [7:0] RST_STOP = 8'h00;
   localparam logic [7:0] RST_SCR = 8'h00;
   localparam logic [10:0] RST_FCR = 11'h000;
   localparam logic [7:0] RST_SMR = 8'h00;
   localparam logic [7:0] RST_BRR = 8'h0F;
   // Idle bit periods before data-ready
   localparam logic [11:0] PEND_IDLE_BITS = 12'h00F;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_st_t;
   typedef enum logic [3:0] {
      REG_STOP, REG_SCR, REG_FCR, REG_FSR, REG_SMR, REG_TDR, REG_RDR, REG_BRR, REG_NONE
   } reg_t;
endpackage
`default_nettype wire

/* File: hw/fifo_async_serial_port.sv */
/*
 FIFO asynchronous serial port with APB register access.
 Assumes synchronous APB and line inputs; one clock; no serial clock pin.
*/
`timescale 1ns/1ps
`default_nettype none
module fifo_async_serial_port #(
   parameter int DEPTH = serial_port_pkg::FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   input wire logic I_CE,
   // APB
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // Serial line
   input wire logic I_RXD,
   output logic O_TXD,
   input wire logic I_CTS_N,
   output logic O_RTS_N,
   // Requests and module stops, this port's own stop among them
   output logic O_TXI,
   output logic O_RXI,
   output logic O_ERI,
   output logic O_BRI,
   output logic [5:0] O_MODULE_STOP
);
   import serial_port_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [4:0] DEP = 5'(DEPTH);

   if (DEPTH < 2 || DEPTH > 16 || (1 << AW) != DEPTH) begin : g_chk
      $error("DEPTH must be a power of two from 2 to 16");
   end

   typedef struct packed {
      logic [7:0] stop;
      logic [7:0] scr;
      logic [10:0] fcr;
      logic [7:0] smr;
      logic [7:0] brr;
      logic [DEPTH-1:0][7:0] tmem;
      logic [4:0] tcnt;
      logic [AW-1:0] twp;
      logic [AW-1:0] trp;
      logic [DEPTH-1:0][9:0] rmem;
      logic [4:0] rcnt;
      logic [AW-1:0] rwp;
      logic [AW-1:0] rrp;
      logic [3:0] fl;
      logic [3:0] seen;
      logic [5:0] pre;
      logic [7:0] tbit;
      logic [11:0] tsh;
      logic [3:0] tleft;
      logic tbusy;
      logic txd;
      rx_st_t rst;
      logic [7:0] rbit;
      logic [10:0] rsh;
      logic [3:0] rleft;
      logic [11:0] idle;
      logic cap;
      logic [31:0] rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   function automatic reg_t dec(input logic [7:0] a);
      unique case (a)
         OFS_STOP: dec = REG_STOP;
         OFS_SCR: dec = REG_SCR;
         OFS_FCR: dec = REG_FCR;
         OFS_FSR: dec = REG_FSR;
         OFS_SMR: dec = REG_SMR;
         OFS_TDR: dec = REG_TDR;
         OFS_RDR: dec = REG_RDR;
         OFS_BRR: dec = REG_BRR;
         default: dec = REG_NONE;
      endcase
   endfunction

   reg_t sel;
   logic run;
   logic done;
   logic rx_in;
   logic len7;
   logic par_en;
   logic odd;
   logic [3:0] dn;
   logic [4:0] tthr;
   logic [4:0] rthr;
   logic [4:0] rts_lvl;
   logic [5:0] div;
   logic [4:0] pc;
   logic [4:0] fc;
   logic [AW-1:0] idx;
   logic [15:0] fsr;
   logic [9:0] head;

   assign run = ~s_q.stop[STOP_SELF];
   assign sel = dec(I_PADDR);
   assign done = I_PSEL & I_PENABLE & I_CE & s_q.cap;
   assign rx_in = s_q.fcr[FCR_LOOP] ? s_q.txd : I_RXD;
   assign O_TXD = s_q.fcr[FCR_LOOP] ? 1'b1 : s_q.txd;
   assign len7 = s_q.smr[SMR_LEN7];
   assign par_en = s_q.smr[SMR_PAR];
   assign odd = par_en & s_q.smr[SMR_OE];
   assign dn = len7 ? 4'd7 : 4'd8;
   assign head = s_q.rmem[s_q.rrp];

   always_comb begin
      unique case (s_q.smr[SMR_CLK_LO +: 2])
         2'b00: div = 6'd1;
         2'b01: div = 6'd4;
         2'b10: div = 6'd16;
         2'b11: div = 6'd63;
      endcase
   end

   always_comb begin
      unique case (s_q.fcr[FCR_RXTH_LO +: 2])
         2'b00: rthr = 5'd1;
         2'b01: rthr = 5'd4;
         2'b10: rthr = 5'd8;
         2'b11: rthr = 5'd14;
      endcase
      if (rthr > DEP) begin
         rthr = DEP;
      end
   end

   always_comb begin
      unique case (s_q.fcr[FCR_TXTH_LO +: 2])
         2'b00: tthr = 5'd8;
         2'b01: tthr = 5'd4;
         2'b10: tthr = 5'd2;
         2'b11: tthr = 5'd0;
      endcase
   end

   always_comb begin
      pc = '0;
      fc = '0;
      idx = '0;
      for (int i = 0; i < DEPTH; i++) begin
         idx = s_q.rrp + AW'(i);
         if (5'(i) < s_q.rcnt) begin
            pc = pc + 5'(s_q.rmem[idx][8]);
            fc = fc + 5'(s_q.rmem[idx][9]);
         end
      end
      if (pc > 5'd15) begin
         pc = 5'd15;
      end
      if (fc > 5'd15) begin
         fc = 5'd15;
      end
   end

   always_comb begin
      fsr = {pc[3:0], fc[3:0], 8'h00};
      fsr[FSR_FAULT] = s_q.fl[FL_FAULT];
      // done only when idle and empty
      fsr[6] = ~s_q.tbusy & (s_q.tcnt == 5'd0);
      fsr[FSR_TXLOW] = s_q.fl[FL_TXLOW];
      fsr[FSR_BREAK] = s_q.fl[FL_BREAK];
      fsr[3] = (s_q.rcnt != 5'd0) & head[9];
      fsr[2] = (s_q.rcnt != 5'd0) & head[8];
      fsr[1] = s_q.rcnt >= rthr;
      fsr[FSR_PEND] = s_q.fl[FL_PEND] & (s_q.rst == RX_IDLE);
   end

   // RTS only with flow control on
   assign rts_lvl = (s_q.fcr[FCR_FLOW_LO +: 3] == 3'd0) ? 5'd15 :
                    5'({s_q.fcr[FCR_FLOW_LO +: 3], 1'b0});
   assign O_RTS_N = ~(s_q.fcr[FCR_FLOW_EN] & (s_q.rcnt < rts_lvl));

   assign O_TXI = s_q.scr[SCR_TXI_EN] & s_q.fl[FL_TXLOW];
   assign O_RXI = s_q.scr[SCR_RXI_EN] & (fsr[1] | fsr[FSR_PEND]);
   assign O_ERI = s_q.scr[SCR_RXI_EN] & s_q.scr[SCR_FLT_EN] & s_q.fl[FL_FAULT];
   assign O_BRI = s_q.scr[SCR_RXI_EN] & s_q.scr[SCR_FLT_EN] & s_q.fl[FL_BREAK];
   assign O_MODULE_STOP = s_q.stop[7:STOP_LO];
   assign O_PRDATA = s_q.rdata;
   assign O_PREADY = I_CE & s_q.cap;
   assign O_PSLVERR = O_PREADY & I_PENABLE & (sel == REG_NONE);

   logic tick;
   logic tpush;
   logic tpop;
   logic rpush;
   logic rpop;
   logic par;
   logic [11:0] f;
   logic [3:0] k;
   logic [10:0] w;
   logic [7:0] rd;
   logic [7:0] msk;
   logic frm_bad;
   logic par_bad;

   always_comb begin
      s_d = s_q;
      tick = 1'b0;
      tpush = 1'b0;
      tpop = 1'b0;
      rpush = 1'b0;
      rpop = 1'b0;
      msk = len7 ? 8'h7F : 8'hFF;
      k = dn + 4'(par_en) + 4'd1;
      f = '1;
      w = '0;
      rd = '0;
      frm_bad = 1'b0;
      par_bad = 1'b0;
      par = ^(s_q.tmem[s_q.trp] & msk) ^ odd;
      // Bus capture once per transfer, survives a held enable
      if (I_PSEL & ~s_q.cap) begin
         s_d.cap = 1'b1;
         s_d.rdata = '0;
         if (~I_PWRITE & (run | sel == REG_STOP)) begin
            unique case (sel)
               REG_STOP: s_d.rdata = 32'(s_q.stop);
               REG_SCR: s_d.rdata = 32'(s_q.scr);
               REG_FCR: s_d.rdata = 32'(s_q.fcr);
               REG_FSR: s_d.rdata = 32'(fsr);
               REG_SMR: s_d.rdata = 32'(s_q.smr);
               REG_BRR: s_d.rdata = 32'(s_q.brr);
               REG_RDR: s_d.rdata = (s_q.rcnt != 5'd0) ? 32'(head[7:0] & msk) : '0;
               default: s_d.rdata = '0;
            endcase
            if (sel == REG_FSR) begin
               for (int i = 0; i < 4; i++) begin
                  s_d.seen[i] = s_q.seen[i] | fsr[FL_POS[i]];
               end
            end
         end
      end
      if (done) begin
         s_d.cap = 1'b0;
         if (I_PWRITE) begin
            if (sel == REG_STOP) begin
               s_d.stop = I_PWDATA[7:0];
            end
            if (run) begin
               unique case (sel)
                  REG_SCR: s_d.scr = I_PWDATA[7:0] & SCR_MASK;
                  REG_FCR: s_d.fcr = I_PWDATA[10:0];
                  REG_SMR: s_d.smr = I_PWDATA[7:0] & SMR_MASK;
                  REG_BRR: s_d.brr = I_PWDATA[7:0];
                  REG_TDR: tpush = s_q.tcnt < DEP;
                  REG_FSR: begin
                     // clear needs an earlier read of one
                     for (int i = 0; i < 4; i++) begin
                        if (~I_PWDATA[FL_POS[i]] & s_q.seen[i]) begin
                           s_d.fl[i] = 1'b0;
                           s_d.seen[i] = 1'b0;
                        end
                     end
                  end
                  default: s_d.cap = 1'b0;
               endcase
            end
         end else if (run & sel == REG_RDR) begin
            rpop = s_q.rcnt != 5'd0;
         end
      end
      if (run) begin
         if (s_q.pre >= div - 6'd1) begin
            s_d.pre = '0;
            tick = 1'b1;
         end else begin
            s_d.pre = s_q.pre + 6'd1;
         end
         if (~s_q.scr[SCR_TX_EN]) begin
            s_d.tbusy = 1'b0;
            s_d.txd = 1'b1;
         end else if (~s_q.tbusy) begin
            if (s_q.tcnt != 5'd0 & (~s_q.fcr[FCR_FLOW_EN] | ~I_CTS_N)) begin
               f[0] = 1'b0;
               for (int i = 0; i < 8; i++) begin
                  if (4'(i) < dn) begin
                     f[i+1] = s_q.tmem[s_q.trp][i];
                  end
               end
               if (par_en) begin
                  f[dn+4'd1] = par;
               end
               tpop = 1'b1;
               s_d.tsh = f;
               s_d.txd = 1'b0;
               s_d.tbusy = 1'b1;
               s_d.tbit = s_q.brr;
               s_d.tleft = k + 4'd1 + 4'(s_q.smr[SMR_STOP]);
            end
         end else if (tick) begin
            if (s_q.tbit != 8'd0) begin
               s_d.tbit = s_q.tbit - 8'd1;
            end else if (s_q.tleft == 4'd1) begin
               s_d.tbusy = 1'b0;
               s_d.txd = 1'b1;
            end else begin
               s_d.tsh = s_q.tsh >> 1;
               s_d.txd = s_q.tsh[1];
               s_d.tleft = s_q.tleft - 4'd1;
               s_d.tbit = s_q.brr;
            end
         end
         unique case (s_q.rst)
            RX_IDLE: begin
               if (s_q.scr[SCR_RX_EN] & ~rx_in) begin
                  s_d.rst = RX_START;
                  s_d.rbit = s_q.brr >> 1;
               end
            end
            RX_START: begin
               if (tick) begin
                  if (s_q.rbit != 8'd0) begin
                     s_d.rbit = s_q.rbit - 8'd1;
                  end else if (rx_in) begin
                     s_d.rst = RX_IDLE;
                  end else begin
                     s_d.rst = RX_DATA;
                     s_d.rbit = s_q.brr;
                     s_d.rleft = k;
                  end
               end
            end
            RX_DATA: begin
               if (tick) begin
                  if (s_q.rbit != 8'd0) begin
                     s_d.rbit = s_q.rbit - 8'd1;
                  end else begin
                     s_d.rsh = {rx_in, s_q.rsh[10:1]};
                     s_d.rleft = s_q.rleft - 4'd1;
                     s_d.rbit = s_q.brr;
                     if (s_q.rleft == 4'd1) begin
                        s_d.rst = RX_IDLE;
                        w = s_d.rsh >> (4'd11 - k);
                        rd = w[7:0] & msk;
                        frm_bad = ~w[k-4'd1];
                        par_bad = par_en & ((^rd ^ odd) != w[dn]);
                        if (frm_bad & rd == 8'h00) begin
                           s_d.fl[FL_BREAK] = 1'b1;
                        end else begin
                           // Full FIFO drops the character
                           rpush = s_q.rcnt < DEP;
                           s_d.fl[FL_FAULT] = s_q.fl[FL_FAULT] | frm_bad | par_bad;
                        end
                     end
                  end
               end
            end
            default: s_d.rst = RX_IDLE;
         endcase
         if (~s_q.scr[SCR_RX_EN]) begin
            s_d.rst = RX_IDLE;
         end
      end
      if (tpush) begin
         s_d.tmem[s_q.twp] = I_PWDATA[7:0];
         s_d.twp = s_q.twp + AW'(1);
      end
      if (tpop) begin
         s_d.trp = s_q.trp + AW'(1);
      end
      s_d.tcnt = s_q.tcnt + 5'(tpush) - 5'(tpop);
      if (rpush) begin
         s_d.rmem[s_q.rwp] = {frm_bad, par_bad, rd};
         s_d.rwp = s_q.rwp + AW'(1);
      end
      if (rpop) begin
         s_d.rrp = s_q.rrp + AW'(1);
      end
      s_d.rcnt = s_q.rcnt + 5'(rpush) - 5'(rpop);
      if (s_q.fcr[FCR_TX_CLR]) begin
         s_d.tcnt = '0;
         s_d.twp = '0;
         s_d.trp = '0;
      end
      if (s_q.fcr[FCR_RX_CLR]) begin
         s_d.rcnt = '0;
         s_d.rwp = '0;
         s_d.rrp = '0;
      end
      // low flag tracks transmit level, set wins
      if (s_d.tcnt <= tthr) begin
         s_d.fl[FL_TXLOW] = 1'b1;
      end else begin
         s_d.fl[FL_TXLOW] = 1'b0;
      end
      // idle line with residue sets pending
      if (s_q.rst != RX_IDLE | rpush | rpop | s_d.rcnt == 5'd0) begin
         s_d.idle = '0;
      end else if (tick & s_q.idle != 12'hFFF) begin
         s_d.idle = s_q.idle + 12'd1;
      end
      if (s_q.idle >= 12'(PEND_IDLE_BITS * ({4'h0, s_q.brr} + 12'd1))) begin
         s_d.fl[FL_PEND] = 1'b1;
      end
      if (s_d.rcnt == 5'd0) begin
         s_d.fl[FL_PEND] = 1'b0;
      end
      if (I_SYS_RST) begin
         s_d = '0;
         s_d.stop = RST_STOP;
         s_d.scr = RST_SCR;
         s_d.fcr = RST_FCR;
         s_d.smr = RST_SMR;
         s_d.brr = RST_BRR;
         s_d.txd = 1'b1;
         s_d.rst = RX_IDLE;
      end
   end

   // Enable low freezes everything but reset
   always_ff @(posedge I_CLK_SYS) begin
      if (I_CE | I_SYS_RST) begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

/* File: tb/fifo_async_serial_port_asserts.sv */
/*
 Checker for the serial port: bus answer, request gating, line idle.
 Bound to the port's top module; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker
   import serial_port_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   input wire logic I_CE,
   // Bus
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   // Line and requests
   input wire logic O_TXD,
   input wire logic O_RTS_N,
   input wire logic O_TXI,
   input wire logic O_RXI,
   input wire logic O_ERI,
   input wire logic O_BRI,
   input wire logic [5:0] O_MODULE_STOP
);
   logic [7:0] scr_q;
   logic flow_q;
   logic acc;
   logic done;
   assign done = I_PSEL & I_PENABLE & O_PREADY & I_CE;
   // Stopped port ignores writes, so shadow must too
   assign acc = done & I_PWRITE & ~O_MODULE_STOP[STOP_SELF-STOP_LO];
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SYS_RST) begin
         scr_q <= 8'h00;
         flow_q <= 1'b0;
      end else begin
         if (acc && I_PADDR == OFS_SCR) begin
            scr_q <= I_PWDATA[7:0];
         end
         if (acc && I_PADDR == OFS_FCR) begin
            flow_q <= I_PWDATA[FCR_FLOW_EN];
         end
      end
   end
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);
   txi_gate_a: assert property (
      !scr_q[SCR_TXI_EN] |-> !O_TXI) else $error("Transmit request while gated");
   rx_gate_a: assert property (
      !scr_q[SCR_RXI_EN] |-> !(O_RXI || O_ERI || O_BRI))
      else $error("Receive request while gated");
   fault_gate_a: assert property (
      !scr_q[SCR_FLT_EN] |-> !(O_ERI || O_BRI)) else $error("Fault request while gated");
   tx_idle_a: assert property (
      !scr_q[SCR_TX_EN] |=> O_TXD) else $error("Line active with transmitter off");
   rts_off_a: assert property (
      !flow_q |-> O_RTS_N) else $error("Send request active without flow control");
   stop_out_a: assert property (
      done && I_PWRITE && I_PADDR == OFS_STOP |=> O_MODULE_STOP == $past(I_PWDATA[7:2]))
      else $error("Module stop outputs wrong");
   bus_ready_a: assert property (
      I_PSEL && !I_PENABLE && I_CE |=> O_PREADY) else $error("No answer after setup");
   bus_err_a: assert property (
      done |-> O_PSLVERR == (I_PADDR > OFS_BRR || I_PADDR[1:0] != 2'b00))
      else $error("Error response wrong");
   cover property ($fell(O_TXD));
   cover property ($rose(O_RXI));
   cover property ($rose(O_BRI));
   cover property (O_PSLVERR);
endmodule
bind fifo_async_serial_port serial_port_checker serial_port_checker_i (
   .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_TXD(O_TXD), .O_RTS_N(O_RTS_N),
   .O_TXI(O_TXI), .O_RXI(O_RXI), .O_ERI(O_ERI), .O_BRI(O_BRI), .O_MODULE_STOP(O_MODULE_STOP));
`default_nettype wire

/* File: tb/remote_serial_dev.sv */
/*
 Remote serial partner: sends and captures start/stop framed bytes.
 Assumes a fixed bit time of BIT clock cycles, line idle high.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_serial_dev #(
   parameter int BIT = 4
) (
   // Clock
   input wire logic i_clk,
   // Line from the port and line to the port
   input wire logic i_line,
   output logic o_line
);
   int rx_n;
   logic [7:0] rx_last;
   logic [7:0] d;
   initial begin
      o_line = 1'b1;
      rx_n = 0;
      rx_last = 8'h00;
   end
   // 8N1 capture, LSB first
   // Sampled at the falling edge, away from the port's updates
   initial forever begin
      @(negedge i_clk);
      if (i_line === 1'b0) begin
         repeat (BIT / 2) @(negedge i_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge i_clk);
            d[i] = i_line;
         end
         repeat (BIT) @(negedge i_clk);
         if (i_line === 1'b1) begin
            rx_last = d;
            rx_n++;
         end
      end
   end
   // Start, 8 bits, stop; low stop makes a fault, or a break when the data is zero
   task automatic send(input logic [7:0] v, input logic stp);
      o_line <= 1'b0;
      repeat (BIT) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         o_line <= v[i];
         repeat (BIT) @(posedge i_clk);
      end
      o_line <= stp;
      repeat (BIT) @(posedge i_clk);
      o_line <= 1'b1;
      repeat (2 * BIT) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

/* File: tb/fifo_async_serial_port_tb_top.sv */
/*
 Testbench for the serial port: APB register tasks and line traffic.
 Assumes bit-rate value 3 and a partner with a four-cycle bit.
*/
`timescale 1ns/1ps
`default_nettype none
module fifo_async_serial_port_tb_top;
   import serial_port_pkg::*;
   logic clk, rst, psel, penable, pwrite, slv_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic pready, pslverr, rxd, txd, rts_n, txi, rxi, eri, bri;
   logic [5:0] mstop;
   int n_mismatch, n_checks;
   always #10 clk = ~clk;
   fifo_async_serial_port fifo_async_serial_port_i (
      .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RXD(rxd),
      .O_TXD(txd), .I_CTS_N(1'b1), .O_RTS_N(rts_n), .O_TXI(txi), .O_RXI(rxi),
      .O_ERI(eri), .O_BRI(bri), .O_MODULE_STOP(mstop));
   remote_serial_dev #(.BIT(4)) remote_serial_dev_i (
      .i_clk(clk), .i_line(txd), .o_line(rxd));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Bounded wait, no latency assumed; read at the edge, before it updates
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_mismatch++;
      end
      rv = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk(rv & m, e);
   endtask
   task automatic wait_tx(input int n);
      int k;
      k = 0;
      while (remote_serial_dev_i.rx_n != n && k < 3000) begin
         @(posedge clk);
         k++;
      end
      chk(32'(remote_serial_dev_i.rx_n), 32'(n));
      repeat (10) @(posedge clk);
   endtask
   task automatic conclude();
      $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(OFS_SCR, 32'hFF, 32'h0);
      rd(OFS_FCR, 32'h7FF, 32'h0);
      rd(OFS_BRR, 32'hFF, 32'h0F);
      rd(OFS_FSR, 32'hFFBF, 32'h20);
      rd(8'h20, 32'hFFFF_FFFF, 32'h0);
      chk(32'(slv_err), 32'h1);
      wr(OFS_STOP, 32'hBC);
      chk(32'(mstop), 32'h2F);
      wr(OFS_SCR, 32'h70);
      rd(OFS_SCR, 32'hFF, 32'h70);
      wr(OFS_STOP, 32'hFC);
      rd(OFS_SCR, 32'hFF, 32'h0);
      wr(OFS_SCR, 32'h0);
      wr(OFS_STOP, 32'h0);
      rd(OFS_SCR, 32'hFF, 32'h70);
      wr(OFS_SCR, 32'hF0);
      chk(32'(txi), 32'h1);
      wr(OFS_SCR, 32'h70);
      // Parity sense set but parity off: frame must stay 8N1
      wr(OFS_BRR, 32'h3);
      wr(OFS_SMR, 32'h10);
      wr(OFS_FCR, 32'h80);
      wr(OFS_TDR, 32'h5A);
      rd(OFS_FSR, 32'h40, 32'h0);
      wait_tx(1);
      chk(32'(remote_serial_dev_i.rx_last), 32'h5A);
      rd(OFS_FSR, 32'h40, 32'h40);
      wr(OFS_SCR, 32'h50);
      for (int i = 0; i < 17; i++) begin
         wr(OFS_TDR, 32'(i));
      end
      rd(OFS_FSR, 32'h20, 32'h0);
      chk(32'(remote_serial_dev_i.rx_n), 32'h1);
      wr(OFS_SCR, 32'h70);
      wait_tx(17);
      chk(32'(remote_serial_dev_i.rx_last), 32'h0F);
      wr(OFS_SCR, 32'h50);
      wr(OFS_TDR, 32'h11);
      wr(OFS_FCR, 32'h84);
      wr(OFS_FCR, 32'h80);
      rd(OFS_FSR, 32'h20, 32'h20);
      wr(OFS_SCR, 32'h70);
      repeat (100) @(posedge clk);
      chk(32'(remote_serial_dev_i.rx_n), 32'd17);
      for (int i = 0; i < 8; i++) begin
         if (i == 7) begin
            rd(OFS_FSR, 32'h2, 32'h0);
         end
         remote_serial_dev_i.send(8'hA0 + 8'(i), 1'b1);
      end
      rd(OFS_FSR, 32'h2, 32'h2);
      chk(32'(rxi), 32'h1);
      repeat (80) @(posedge clk);
      rd(OFS_FSR, 32'h1, 32'h1);
      for (int i = 0; i < 8; i++) begin
         rd(OFS_RDR, 32'hFF, 32'hA0 + 32'(i));
      end
      rd(OFS_FSR, 32'h3, 32'h0);
      wr(OFS_SCR, 32'h60);
      remote_serial_dev_i.send(8'h33, 1'b1);
      rd(OFS_RDR, 32'hFF, 32'h0);
      wr(OFS_SCR, 32'h70);
      wr(OFS_FCR, 32'h81);
      wr(OFS_TDR, 32'hC3);
      repeat (80) @(posedge clk);
      rd(OFS_RDR, 32'hFF, 32'hC3);
      chk(32'(remote_serial_dev_i.rx_n), 32'd17);
      wr(OFS_FCR, 32'h80);
      remote_serial_dev_i.send(8'h55, 1'b0);
      repeat (20) @(posedge clk);
      rd(OFS_FSR, 32'hFF80, 32'h180);
      chk(32'(eri), 32'h0);
      wr(OFS_SCR, 32'h78);
      chk(32'(eri), 32'h1);
      remote_serial_dev_i.send(8'h00, 1'b0);
      repeat (20) @(posedge clk);
      rd(OFS_FSR, 32'h10, 32'h10);
      chk(32'(bri), 32'h1);
      wr(OFS_SCR, 32'h38);
      chk(32'({eri, bri}), 32'h0);
      wr(OFS_FSR, 32'h0);
      rd(OFS_FSR, 32'h90, 32'h0);
      wr(OFS_FCR, 32'h82);
      wr(OFS_FCR, 32'h80);
      rd(OFS_FSR, 32'hFF00, 32'h0);
      rd(OFS_RDR, 32'hFF, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
